/* File: src/atc_pkg.sv */
// Purpose: shared constants for the acquisition trigger controller
// Assumes: core clock of 50 MHz, delay programmed in 0.1 ms steps
// Notes:   register offsets are byte addresses on the plain register port
package atc_pkg;
   // clock and time base
   localparam int CLK_PERIOD_NS = 20;
   localparam int DELAY_STEP_NS = 100_000;
   localparam int STEP_CYC = DELAY_STEP_NS / CLK_PERIOD_NS;
   // delay limits, as times in microseconds, counted in delay steps
   localparam int STEP_US = 100;
   localparam int POS_MAX_US = 1_000_000;
   localparam int NEG_MIN_US = 42_600;
   localparam int NEG_MAX_US = 426_000;
   localparam int POS_MAX_STEPS = POS_MAX_US / STEP_US;
   localparam int NEG_MIN_STEPS = NEG_MIN_US / STEP_US;
   localparam int NEG_MAX_STEPS = NEG_MAX_US / STEP_US;
   // acquisition window depth in samples, one sample per delay step
   localparam int WIN_SAMPLES = NEG_MAX_STEPS;
   localparam int BUF_DEPTH = 8192;

   // register port
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_DELAY = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_WIN_START = 8'h0C;
   localparam logic [7:0] REG_RD_INDEX = 8'h10;
   localparam logic [7:0] REG_RD_DATA = 8'h14;

   // control fields
   localparam int CTRL_START_BIT = 0;
   localparam int CTRL_ABORT_BIT = 1;
   localparam int CTRL_REARM_BIT = 2;
   localparam int CTRL_ORIGIN_BIT = 3;
   localparam int CTRL_PHASE_LSB = 4;
   localparam int PHASE_W = 2;
   // status fields
   localparam int STAT_STATE_LSB = 0;
   localparam int STAT_DONE_BIT = 2;
   localparam int STAT_COUNT_LSB = 8;
   localparam int COUNT_W = 8;

   localparam int DELAY_W = 16;
   localparam logic [DELAY_W-1:0] DELAY_RESET = 16'h0000;

   typedef enum logic [1:0] {
      ORIGIN_IMMEDIATE = 2'b00,
      ORIGIN_PHASE = 2'b01
   } atc_origin_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ARMED = 2'b01,
      ST_HOLDOFF = 2'b11,
      ST_CAPTURE = 2'b10
   } atc_state_t;
endpackage

/* File: src/atc_sample_mem.sv */
// Purpose: circular sample store with one write and one registered read port
// Assumes: single clock, read data one cycle after the address
// Notes:   no reset on the array; contents are undefined until written
`timescale 1ns/1ns
module atc_sample_mem #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8192,
   parameter int AW = 13
) (
   // clock
   input wire logic core_clk,
   // write side
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   // read side
   input wire logic [AW-1:0] rd_addr,
   output logic [WIDTH-1:0] rd_data
);
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge core_clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge core_clk) begin
      rd_data <= mem[rd_addr];
   end
endmodule // atc_sample_mem

/* File: src/atc_trigger_ctrl.sv */
// Purpose: arms, triggers and positions a sample acquisition window
// Assumes: inputs synchronous to core_clk; zero-phase inputs are one-cycle pulses
// Notes:   one sample of the selected phase is stored every delay step while not idle
`timescale 1ns/1ns
// Overview of operation
// - one-shot: a start arms once, waits for a trigger, captures one set
// - one-shot: returns to idle after capture; a fresh start is needed again
// - auto-rearm: re-arms after every capture, each trigger gives a new set
// - immediate source: trigger follows the start with no condition checked
// - phase source: trigger waits for zero phase of output voltage
// - phase trigger uses voltage phase only, never current
// - phase trigger uses the first zero point after each arming only
// - positive delay holds off capture for the programmed time after trigger
// - positive delay spans 0 to 1 s in 0.1 ms steps
// - negative delay starts the window that long before the trigger
// - negative delay magnitude limited to the window depth
// - negative delay magnitude spans 42.6 ms to 426 ms
// - host picks one of three phases; block samples and triggers on it
module atc_trigger_ctrl #(
   parameter int SAMPLE_W = 16,
   parameter int STEP_CYC = atc_pkg::STEP_CYC,
   parameter int WIN = atc_pkg::WIN_SAMPLES,
   parameter int DEPTH = atc_pkg::BUF_DEPTH
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // register port
   input wire logic [atc_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [atc_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [atc_pkg::DATA_W-1:0] reg_rdata,
   // output voltage zero-phase pulses, one per phase
   input wire logic [2:0] volt_zero_pulse,
   // sample inputs, one per phase
   input wire logic [SAMPLE_W-1:0] sample_a,
   input wire logic [SAMPLE_W-1:0] sample_b,
   input wire logic [SAMPLE_W-1:0] sample_c,
   // status
   output logic acq_busy,
   output logic acq_done_pulse
);
   localparam int AW = $clog2(DEPTH);
   localparam int DW = atc_pkg::DELAY_W;
   localparam int NEG_LIM = (atc_pkg::NEG_MAX_STEPS < WIN) ? atc_pkg::NEG_MAX_STEPS : WIN;

   generate
      if (WIN > DEPTH || WIN < atc_pkg::NEG_MIN_STEPS || (1 << AW) != DEPTH || STEP_CYC < 2 ||
          SAMPLE_W > atc_pkg::DATA_W || WIN >= (1 << (DW - 1)) || STEP_CYC > 32'h0001_0000) begin : g_bad_params
         $error("atc_trigger_ctrl: unsupported parameter values");
      end
   endgenerate

   // keeps a written delay inside the legal ranges
   function automatic logic [DW-1:0] clamp_delay(input logic [DW-1:0] v);
      logic [DW-1:0] mag;
      mag = '0;
      if (!v[DW-1]) begin
         if (v > DW'(atc_pkg::POS_MAX_STEPS)) begin
            return DW'(atc_pkg::POS_MAX_STEPS);
         end
         return v;
      end
      mag = DW'(-v);
      if (mag < DW'(atc_pkg::NEG_MIN_STEPS)) begin
         mag = DW'(atc_pkg::NEG_MIN_STEPS);
      end
      if (mag > DW'(NEG_LIM)) begin
         mag = DW'(NEG_LIM);
      end
      return DW'(-mag);
   endfunction

   // picks the selected phase out of three
   function automatic logic [SAMPLE_W-1:0] pick_sample(input logic [1:0] sel, input logic [SAMPLE_W-1:0] a,
                                                       input logic [SAMPLE_W-1:0] b,
                                                       input logic [SAMPLE_W-1:0] c);
      unique case (sel)
         2'd1: return b;
         2'd2: return c;
         default: return a;
      endcase
   endfunction

   // settings
   logic rearm_q;
   logic origin_q;
   logic [1:0] phase_sel_q;
   logic [DW-1:0] delay_q;
   logic [AW-1:0] rd_index_q;
   // sequencer
   atc_pkg::atc_state_t state_q;
   atc_pkg::atc_state_t state_d;
   logic [15:0] tick_cnt_q;
   logic [AW-1:0] wr_ptr_q;
   logic [AW-1:0] start_q;
   logic [AW-1:0] win_start_q;
   logic [DW-1:0] remain_q;
   logic done_q;
   logic [atc_pkg::COUNT_W-1:0] cap_cnt_q;
   logic [SAMPLE_W-1:0] mem_rdata;

   logic wr_ctrl;
   logic start_cmd;
   logic abort_cmd;
   logic tick;
   logic buf_wr;
   logic trig;
   logic finish;
   logic zero_sel;
   logic [DW-1:0] neg_mag;

   assign wr_ctrl = reg_wr && (reg_addr == atc_pkg::REG_CTRL);
   assign start_cmd = wr_ctrl && reg_wdata[atc_pkg::CTRL_START_BIT];
   assign abort_cmd = wr_ctrl && reg_wdata[atc_pkg::CTRL_ABORT_BIT];
   assign tick = (tick_cnt_q == 16'(STEP_CYC - 1));
   assign buf_wr = tick && (state_q != atc_pkg::ST_IDLE);
   assign zero_sel = volt_zero_pulse[phase_sel_q];
   assign neg_mag = DW'(-delay_q);
   // only pulses seen in the armed state count, never one from before the start
   assign trig = (state_q == atc_pkg::ST_ARMED) && !abort_cmd &&
                 ((origin_q == 1'(atc_pkg::ORIGIN_IMMEDIATE)) || zero_sel);
   assign finish = (state_q == atc_pkg::ST_CAPTURE) && !abort_cmd &&
                   ((remain_q == '0) || (buf_wr && remain_q == DW'(1)));

   // settings registers
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rearm_q <= 1'b0;
         origin_q <= 1'b0;
         phase_sel_q <= '0;
      end else if (wr_ctrl) begin
         rearm_q <= reg_wdata[atc_pkg::CTRL_REARM_BIT];
         origin_q <= reg_wdata[atc_pkg::CTRL_ORIGIN_BIT];
         if (reg_wdata[atc_pkg::CTRL_PHASE_LSB +: atc_pkg::PHASE_W] != 2'd3) begin
            phase_sel_q <= reg_wdata[atc_pkg::CTRL_PHASE_LSB +: atc_pkg::PHASE_W];
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         delay_q <= atc_pkg::DELAY_RESET;
      end else if (reg_wr && reg_addr == atc_pkg::REG_DELAY) begin
         delay_q <= clamp_delay(reg_wdata[DW-1:0]);
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rd_index_q <= '0;
      end else if (reg_wr && reg_addr == atc_pkg::REG_RD_INDEX) begin
         rd_index_q <= reg_wdata[AW-1:0];
      end
   end

   // sample time base
   always_ff @(posedge core_clk) begin
      if (sys_rst || tick) begin
         tick_cnt_q <= '0;
      end else begin
         tick_cnt_q <= tick_cnt_q + 16'd1;
      end
   end

   // circular write pointer
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         wr_ptr_q <= '0;
      end else if (buf_wr) begin
         wr_ptr_q <= wr_ptr_q + AW'(1);
      end
   end

   // state sequence
   always_comb begin
      state_d = state_q;
      unique case (state_q)
         atc_pkg::ST_IDLE: begin
            if (start_cmd && !abort_cmd) begin
               state_d = atc_pkg::ST_ARMED;
            end
         end
         atc_pkg::ST_ARMED: begin
            if (abort_cmd) begin
               state_d = atc_pkg::ST_IDLE;
            end else if (trig) begin
               if (!delay_q[DW-1] && delay_q != '0) begin
                  state_d = atc_pkg::ST_HOLDOFF;
               end else begin
                  state_d = atc_pkg::ST_CAPTURE;
               end
            end
         end
         atc_pkg::ST_HOLDOFF: begin
            if (abort_cmd) begin
               state_d = atc_pkg::ST_IDLE;
            end else if (tick && remain_q == DW'(1)) begin
               state_d = atc_pkg::ST_CAPTURE;
            end
         end
         atc_pkg::ST_CAPTURE: begin
            if (abort_cmd) begin
               state_d = atc_pkg::ST_IDLE;
            end else if (finish) begin
               state_d = rearm_q ? atc_pkg::ST_ARMED : atc_pkg::ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state_q <= atc_pkg::ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // holdoff and capture counting, window position
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         remain_q <= '0;
         start_q <= '0;
      end else if (trig) begin
         if (delay_q[DW-1]) begin
            start_q <= wr_ptr_q - AW'(neg_mag);
            remain_q <= DW'(WIN) - neg_mag;
         end else if (delay_q != '0) begin
            remain_q <= delay_q;
         end else begin
            start_q <= wr_ptr_q;
            remain_q <= DW'(WIN);
         end
      end else if (state_q == atc_pkg::ST_HOLDOFF && tick) begin
         if (remain_q == DW'(1)) begin
            start_q <= wr_ptr_q + AW'(1);
            remain_q <= DW'(WIN);
         end else begin
            remain_q <= remain_q - DW'(1);
         end
      end else if (state_q == atc_pkg::ST_CAPTURE && buf_wr && remain_q != '0) begin
         remain_q <= remain_q - DW'(1);
      end
   end

   // completed window and result count
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         win_start_q <= '0;
         cap_cnt_q <= '0;
      end else if (finish) begin
         win_start_q <= start_q;
         cap_cnt_q <= cap_cnt_q + atc_pkg::COUNT_W'(1);
      end
   end

   // sticky done flag; a new completion wins over the clear
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         done_q <= 1'b0;
      end else if (finish) begin
         done_q <= 1'b1;
      end else if (reg_wr && reg_addr == atc_pkg::REG_STATUS && reg_wdata[atc_pkg::STAT_DONE_BIT]) begin
         done_q <= 1'b0;
      end
   end

   atc_sample_mem #(
      .WIDTH(SAMPLE_W),
      .DEPTH(DEPTH),
      .AW(AW)
   ) u_mem (
      .core_clk(core_clk),
      .wr_en(buf_wr),
      .wr_addr(wr_ptr_q),
      .wr_data(pick_sample(phase_sel_q, sample_a, sample_b, sample_c)),
      .rd_addr(win_start_q + rd_index_q),
      .rd_data(mem_rdata)
   );

   // register read, data in the cycle after the strobe
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         reg_rdata <= '0;
         unique case (reg_addr)
            atc_pkg::REG_CTRL: begin
               reg_rdata[atc_pkg::CTRL_REARM_BIT] <= rearm_q;
               reg_rdata[atc_pkg::CTRL_ORIGIN_BIT] <= origin_q;
               reg_rdata[atc_pkg::CTRL_PHASE_LSB +: atc_pkg::PHASE_W] <= phase_sel_q;
            end
            atc_pkg::REG_DELAY: begin
               reg_rdata <= {{(atc_pkg::DATA_W - DW){delay_q[DW-1]}}, delay_q};
            end
            atc_pkg::REG_STATUS: begin
               reg_rdata[atc_pkg::STAT_STATE_LSB +: 2] <= state_q;
               reg_rdata[atc_pkg::STAT_DONE_BIT] <= done_q;
               reg_rdata[atc_pkg::STAT_COUNT_LSB +: atc_pkg::COUNT_W] <= cap_cnt_q;
            end
            atc_pkg::REG_WIN_START: begin
               reg_rdata[AW-1:0] <= win_start_q;
            end
            atc_pkg::REG_RD_INDEX: begin
               reg_rdata[AW-1:0] <= rd_index_q;
            end
            atc_pkg::REG_RD_DATA: begin
               reg_rdata[SAMPLE_W-1:0] <= mem_rdata;
            end
            default: begin
               reg_rdata <= '0;
            end
         endcase
      end else begin
         reg_rdata <= '0;
      end
   end

   assign acq_busy = (state_q != atc_pkg::ST_IDLE);
   assign acq_done_pulse = finish;
endmodule // atc_trigger_ctrl

/* File: tb/acquisition_trigger_control_tb.sv */
// Purpose: self-checking bench for the trigger controller
// Assumes: short step and window parameters
// Notes: capture durations allow two steps of slack
`timescale 1ns/1ns
module acquisition_trigger_control_tb;
   localparam int STEP = 4;
   localparam int WIN = 500;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0000_0000;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [2:0] fire = 3'b000;
   logic [31:0] reg_rdata;
   logic [31:0] got;
   logic [2:0] volt_zero_pulse;
   logic [15:0] sample_a;
   logic [15:0] sample_b;
   logic [15:0] sample_c;
   logic acq_busy;
   logic acq_done_pulse;
   int n_fail = 0;
   int comparisons = 0;
   int ncap = 0;
   int cyc;
   int d;
   int dly[5] = '{5, 20000, -100, -4000, -450};
   atc_trigger_ctrl #(.STEP_CYC(STEP), .WIN(WIN), .DEPTH(1024)) dut_u (.core_clk, .sys_rst, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .volt_zero_pulse, .sample_a, .sample_b, .sample_c,
      .acq_busy, .acq_done_pulse);
   atc_phase_src src_u (.core_clk, .sys_rst, .fire, .volt_zero_pulse, .sample_a, .sample_b, .sample_c);
   initial begin
      forever #10 core_clk = ~core_clk;
   end
   function automatic int clampd(int v);
      if (v > 10000) return 10000;
      if (v >= 0) return v;
      if (-v < 426) return -426;
      if (-v > WIN) return -WIN;
      return v;
   endfunction
   task automatic summarize();
      if (n_fail == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("BAD %s expected %0h seen %0h", nm, e, g);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] v);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(logic [7:0] a, output logic [31:0] v);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 v = reg_rdata;
   endtask
   task automatic pulse(logic [2:0] m);
      @(posedge core_clk);
      fire <= m;
      @(posedge core_clk);
      fire <= 3'b000;
   endtask
   // cycles until the done pulse, model figure plus or minus two steps
   task automatic wait_done(int e, string nm);
      cyc = 0;
      do begin
         @(posedge core_clk);
         #1 cyc++;
      end while (acq_done_pulse !== 1'b1 && cyc < 30000);
      if (cyc >= 30000) begin
         n_fail++;
         summarize();
      end else begin
         ncap++;
         chk(nm, 1, cyc >= e - 2 * STEP && cyc <= e + 2 * STEP);
      end
   endtask
   initial begin
      d = $urandom(87042);
      repeat (3) @(posedge core_clk);
      sys_rst <= 1'b0;
      foreach (dly[i]) begin
         wr(atc_pkg::REG_DELAY, 32'(dly[i]));
         rd(atc_pkg::REG_DELAY, got);
         chk("delay", 32'(clampd(dly[i])), got);
      end
      rd(8'h20, got);
      chk("unmapped", 0, got);
      d = $urandom_range(8, 1);
      wr(atc_pkg::REG_DELAY, 32'(d));
      wr(atc_pkg::REG_CTRL, 32'h0000_0001);
      wait_done((WIN + d) * STEP, "post");
      repeat (20) @(posedge core_clk);
      rd(atc_pkg::REG_STATUS, got);
      chk("status", 32'h0000_0104, got);
      for (int m = 450; m <= WIN; m += WIN - 450) begin
         wr(atc_pkg::REG_DELAY, 32'(-m));
         wr(atc_pkg::REG_CTRL, 32'h0000_0001);
         wait_done((WIN - m) * STEP, "pre");
      end
      wr(atc_pkg::REG_DELAY, 32'h0000_0000);
      for (int p = 0; p < 3; p++) begin
         pulse(3'(1 << p));
         wr(atc_pkg::REG_CTRL, 32'(p * 16 + 9));
         rd(atc_pkg::REG_CTRL, got);
         chk("ctrl", 32'(p * 16 + 8), got);
         pulse(3'b111 ^ 3'(1 << p));
         repeat ($urandom_range(60, 20)) @(posedge core_clk);
         pulse(3'(1 << p));
         wait_done(WIN * STEP, "phase");
         // two neighbouring window samples of the chosen ramp, one step apart
         wr(atc_pkg::REG_RD_INDEX, 32'h0000_0000);
         rd(atc_pkg::REG_RD_DATA, got);
         d = int'(got);
         wr(atc_pkg::REG_RD_INDEX, 32'h0000_0001);
         rd(atc_pkg::REG_RD_DATA, got);
         chk("sample step", 32'(16'(d + STEP * (p + 1))), got);
      end
      wr(atc_pkg::REG_CTRL, 32'h0000_0005);
      wait_done(WIN * STEP, "auto1");
      wait_done(WIN * STEP, "auto2");
      wr(atc_pkg::REG_CTRL, 32'h0000_0002);
      rd(atc_pkg::REG_STATUS, got);
      chk("status", 32'(ncap * 256 + 4), got);
      wr(atc_pkg::REG_STATUS, 32'h0000_0004);
      rd(atc_pkg::REG_STATUS, got);
      chk("done clear", 32'(ncap * 256), got);
      // phase code 3 is refused, the old phase stays
      wr(atc_pkg::REG_CTRL, 32'h0000_0038);
      rd(atc_pkg::REG_CTRL, got);
      chk("ctrl", 32'h0000_0008, got);
      summarize();
   end
endmodule // acquisition_trigger_control_tb

/* File: tb/atc_checker_assertions.sv */
// Purpose: port assertions for the trigger controller
// Assumes: one clock, synchronous active-high reset
// Notes: auto-rearm setting tracked from control writes
`timescale 1ns/1ns
module atc_checker (
   // clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // register port
   input wire logic [atc_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [atc_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [atc_pkg::DATA_W-1:0] reg_rdata,
   // status
   input wire logic acq_busy,
   input wire logic acq_done_pulse
);
   logic rearm_q;
   logic ctl_wr;
   assign ctl_wr = reg_wr && reg_addr == atc_pkg::REG_CTRL;
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rearm_q <= 1'b0;
      end else if (ctl_wr) begin
         rearm_q <= reg_wdata[atc_pkg::CTRL_REARM_BIT];
      end
   end
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);
   start_arms_a: assert property (ctl_wr && reg_wdata[0] && !reg_wdata[1] && !acq_busy |=> acq_busy)
      else $error("start left block idle");
   idle_hold_a: assert property (!acq_busy && !(ctl_wr && reg_wdata[0]) |=> !acq_busy)
      else $error("left idle without start");
   done_idle_a: assert property (acq_done_pulse && !rearm_q && !ctl_wr |=> !acq_busy)
      else $error("one-shot not idle after done");
   rearm_busy_a: assert property (acq_done_pulse && rearm_q && !ctl_wr |=> acq_busy)
      else $error("auto mode did not rearm");
   done_busy_a: assert property (acq_done_pulse |-> acq_busy)
      else $error("done while idle");
   done_single_a: assert property (acq_done_pulse |=> !acq_done_pulse)
      else $error("done pulse too long");
   state_read_a: assert property (reg_rd && reg_addr == atc_pkg::REG_STATUS
      |=> (reg_rdata[1:0] != 2'b00) == $past(acq_busy))
      else $error("status state disagrees with busy");
   abort_idle_a: assert property (ctl_wr && reg_wdata[1] |=> !acq_busy)
      else $error("abort did not idle");
endmodule // atc_checker
bind atc_trigger_ctrl atc_checker chk_u (.core_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
   .reg_rdata, .acq_busy, .acq_done_pulse);

/* File: tb/atc_phase_src.sv */
// Purpose: far-side model of voltage zero points and phase samples
// Assumes: a fire request shows as a pulse one cycle later
// Notes: no current phase is offered at all
`timescale 1ns/1ns
module atc_phase_src (
   // clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   // requests from the bench
   input wire logic [2:0] fire,
   // towards the controller
   output logic [2:0] volt_zero_pulse,
   output logic [15:0] sample_a,
   output logic [15:0] sample_b,
   output logic [15:0] sample_c
);
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         volt_zero_pulse <= 3'b000;
      end else begin
         volt_zero_pulse <= fire;
      end
   end
   // phases ramp at different rates
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         sample_a <= 16'h0000;
         sample_b <= 16'h0000;
         sample_c <= 16'h0000;
      end else begin
         sample_a <= sample_a + 16'h0001;
         sample_b <= sample_b + 16'h0002;
         sample_c <= sample_c + 16'h0003;
      end
   end
endmodule // atc_phase_src
